// ==== hw/uart_flag_pkg.sv ====
package uart_flag_pkg;
    // Register indices; byte address is four times the index
    localparam logic [29:0] IDX_CLOCK_SELECT = 30'h00005200;
    localparam logic [29:0] IDX_LINE_MODE    = 30'h00005202;
    localparam logic [29:0] IDX_BAUD_DIVIDER = 30'h00005204;
    localparam logic [29:0] IDX_PORT_CONTROL = 30'h00005206;
    localparam logic [29:0] IDX_TRANSMIT     = 30'h00005208;
    localparam logic [29:0] IDX_RECEIVE      = 30'h0000520a;
    localparam logic [29:0] IDX_STATUS       = 30'h0000520c;
    localparam logic [29:0] IDX_IRQ_ENABLES  = 30'h0000520e;
    // Writable bit masks
    localparam logic [15:0] MASK_CLOCK_SELECT = 16'h0133;
    localparam logic [15:0] MASK_LINE_MODE    = 16'h037f;
    localparam logic [15:0] MASK_BAUD_DIVIDER = 16'h0fff;
    localparam logic [15:0] MASK_PORT_CONTROL = 16'h0003;
    localparam logic [15:0] MASK_IRQ_ENABLES  = 16'h007f;
    // Reset values
    localparam logic [15:0] RST_CONFIG = 16'h0000;
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic        RST_TBE    = 1'b1;
    // Control fields
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_SOFT_RESET_BIT = 1;
    // Status and enable fields
    localparam int ST_TBE  = 0;
    localparam int ST_RB1  = 1;
    localparam int ST_RB2  = 2;
    localparam int ST_OE   = 3;
    localparam int ST_PE   = 4;
    localparam int ST_FE   = 5;
    localparam int ST_TEND = 6;
    localparam int ST_TBSY = 8;
    localparam int ST_RBSY = 9;
    localparam int FLAG_COUNT = 7;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== hw/uart_status_flag_logic.sv ====
`timescale 1ns/100ps
module uart_status_flag_logic (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  tx_taken,
    input  wire logic                  tx_end,
    input  wire logic                  tx_busy,
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_byte,
    input  wire logic                  rx_framing_err,
    input  wire logic                  rx_parity_err,
    input  wire logic                  rx_busy,
    output logic [7:0]                 tx_byte,
    output logic                       tx_buffer_empty,
    output logic [15:0]                clock_select,
    output logic [15:0]                line_mode,
    output logic [15:0]                baud_divider,
    output logic                       port_enable,
    output logic                       irq
);
    import uart_flag_pkg::*;

    function automatic logic hit(input logic [31:0] a,
                                 input logic [29:0] idx);
        hit = (a[31:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s,
                                          input logic [15:0] m);
        logic [15:0] lanes;
        lanes = {{8{s[1]}}, {8{s[0]}}} & m;
        merge = (old & ~lanes) | (d[15:0] & lanes);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave state
    logic        awready_reg, wready_reg, bvalid_reg, arready_reg;
    logic        rvalid_reg, aw_held_reg, w_held_reg;
    logic [31:0] aw_addr_reg, w_data_reg, rdata_reg;
    logic [3:0]  w_strb_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    // Registers
    logic [15:0] clk_sel_reg, mode_reg, baud_reg, ctl_reg, inte_reg;
    logic [7:0]  txd_reg;
    logic [7:0]  rx_buf_reg [0:1];
    logic [1:0]  rx_count_reg;
    logic        tbe_reg, oe_reg, pe_reg, fe_reg, tend_reg;
    logic        tbsy_reg, rbsy_reg, irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Decoding
    wire aw_take = s_axi_awvalid && awready_reg;
    wire w_take  = s_axi_wvalid && wready_reg;
    wire wr_do   = aw_held_reg && w_held_reg && !bvalid_reg;
    wire ar_take = s_axi_arvalid && arready_reg;

    wire wr_clk  = wr_do && hit(aw_addr_reg, IDX_CLOCK_SELECT);
    wire wr_mode = wr_do && hit(aw_addr_reg, IDX_LINE_MODE);
    wire wr_baud = wr_do && hit(aw_addr_reg, IDX_BAUD_DIVIDER);
    wire wr_ctl  = wr_do && hit(aw_addr_reg, IDX_PORT_CONTROL);
    wire wr_txd  = wr_do && hit(aw_addr_reg, IDX_TRANSMIT);
    wire wr_rxd  = wr_do && hit(aw_addr_reg, IDX_RECEIVE);
    wire wr_stat = wr_do && hit(aw_addr_reg, IDX_STATUS);
    wire wr_inte = wr_do && hit(aw_addr_reg, IDX_IRQ_ENABLES);
    // Writes to read-only registers answer OKAY and change nothing
    wire wr_ok   = wr_clk || wr_mode || wr_baud || wr_ctl || wr_txd ||
                   wr_rxd || wr_stat || wr_inte;

    wire rd_clk  = hit(s_axi_araddr, IDX_CLOCK_SELECT);
    wire rd_mode = hit(s_axi_araddr, IDX_LINE_MODE);
    wire rd_baud = hit(s_axi_araddr, IDX_BAUD_DIVIDER);
    wire rd_ctl  = hit(s_axi_araddr, IDX_PORT_CONTROL);
    wire rd_txd  = hit(s_axi_araddr, IDX_TRANSMIT);
    wire rd_rxd  = hit(s_axi_araddr, IDX_RECEIVE);
    wire rd_stat = hit(s_axi_araddr, IDX_STATUS);
    wire rd_inte = hit(s_axi_araddr, IDX_IRQ_ENABLES);
    wire rd_ok   = rd_clk || rd_mode || rd_baud || rd_ctl || rd_txd ||
                   rd_rxd || rd_stat || rd_inte;

    // Side effects need the lane that holds the flag bits
    wire w1c_lane = w_strb_reg[0];
    wire txd_write = wr_txd && w_strb_reg[0];
    wire rxd_read  = ar_take && rd_rxd;
    // Read data is captured at the same edge as the pop, so it is the head
    wire soft_rst  = ctl_reg[CTL_SOFT_RESET_BIT];

    wire [15:0] status_word;
    assign status_word = {6'h00, rbsy_reg, tbsy_reg, 1'b0, tend_reg,
                          fe_reg, pe_reg, oe_reg, rx_count_reg == 2'd2,
                          rx_count_reg != 2'd0, tbe_reg};

    wire [15:0] rd_word =
        rd_clk  ? clk_sel_reg :
        rd_mode ? mode_reg :
        rd_baud ? baud_reg :
        rd_ctl  ? ctl_reg :
        rd_txd  ? {8'h00, txd_reg} :
        rd_rxd  ? {8'h00, rx_buf_reg[0]} :
        rd_stat ? status_word :
        rd_inte ? inte_reg : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer, two bytes deep
    wire rx_pop  = rxd_read && (rx_count_reg != 2'd0);
    wire rx_full = (rx_count_reg == 2'd2);
    // A byte landing on a full buffer with no pop in the same cycle is dropped, the buffer keeps its
    // older contents and the overrun flag records the loss
    wire rx_push = rx_valid && (!rx_full || rx_pop);
    wire rx_lost = rx_valid && rx_full && !rx_pop;

    wire [1:0] rx_count_next =
        soft_rst ? 2'd0 :
        (rx_push && !rx_pop) ? rx_count_reg + 2'd1 :
        (rx_pop && !rx_push) ? rx_count_reg - 2'd1 : rx_count_reg;
    wire [1:0] rx_slot = rx_pop ? rx_count_reg - 2'd1 : rx_count_reg;

    ////////////////////////////////////////////////////////////////////////
    // Flags; a setting event beats a clear in the same cycle, and soft reset overrides both
    wire stat_w1c = wr_stat && w1c_lane;
    wire [15:0] wd = w_data_reg[15:0];

    wire tbe_next  = soft_rst ? RST_TBE :
                     tx_taken ? 1'b1 : txd_write ? 1'b0 : tbe_reg;
    wire fe_next   = soft_rst ? 1'b0 :
                     (rx_valid && rx_framing_err) ? 1'b1 :
                     ((stat_w1c && wd[ST_FE]) || rxd_read) ? 1'b0 :
                     fe_reg;
    wire pe_next   = soft_rst ? 1'b0 :
                     (rx_valid && rx_parity_err) ? 1'b1 :
                     ((stat_w1c && wd[ST_PE]) || rxd_read) ? 1'b0 :
                     pe_reg;
    wire oe_next   = soft_rst ? 1'b0 : rx_lost ? 1'b1 :
                     (stat_w1c && wd[ST_OE]) ? 1'b0 : oe_reg;
    wire tend_next = soft_rst ? 1'b0 : tx_end ? 1'b1 :
                     (stat_w1c && wd[ST_TEND]) ? 1'b0 : tend_reg;

    wire [FLAG_COUNT-1:0] pending =
        status_word[FLAG_COUNT-1:0] & inte_reg[FLAG_COUNT-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            aw_addr_reg <= 32'h00000000;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
        end else begin
            // Address and data are held apart so either may come first
            awready_reg <= s_axi_awvalid && !awready_reg && !aw_held_reg;
            wready_reg  <= s_axi_wvalid && !wready_reg && !w_held_reg;
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end else if (wr_do) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
            end else if (wr_do) begin
                w_held_reg <= 1'b0;
            end
            if (wr_do) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= RESP_OKAY;
        end else begin
            // No new address is taken until the last answer is accepted
            arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {16'h0000, rd_word};
                rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sel_reg <= RST_CONFIG;
            mode_reg    <= RST_CONFIG;
            baud_reg    <= RST_CONFIG;
            ctl_reg     <= RST_CONFIG;
            inte_reg    <= RST_CONFIG;
            txd_reg     <= RST_BYTE;
        end else begin
            if (wr_clk)
                clk_sel_reg <= merge(clk_sel_reg, w_data_reg, w_strb_reg,
                                     MASK_CLOCK_SELECT);
            if (wr_mode)
                mode_reg <= merge(mode_reg, w_data_reg, w_strb_reg,
                                  MASK_LINE_MODE);
            if (wr_baud)
                baud_reg <= merge(baud_reg, w_data_reg, w_strb_reg,
                                  MASK_BAUD_DIVIDER);
            if (wr_ctl)
                ctl_reg <= merge(ctl_reg, w_data_reg, w_strb_reg,
                                 MASK_PORT_CONTROL);
            if (wr_inte)
                inte_reg <= merge(inte_reg, w_data_reg, w_strb_reg,
                                  MASK_IRQ_ENABLES);
            if (txd_write)
                txd_reg <= w_data_reg[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags and receive buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tbe_reg      <= RST_TBE;
            fe_reg       <= 1'b0;
            pe_reg       <= 1'b0;
            oe_reg       <= 1'b0;
            tend_reg     <= 1'b0;
            tbsy_reg     <= 1'b0;
            rbsy_reg     <= 1'b0;
            rx_count_reg <= 2'd0;
            rx_buf_reg[0] <= RST_BYTE;
            rx_buf_reg[1] <= RST_BYTE;
            irq_reg      <= 1'b0;
        end else begin
            tbe_reg  <= tbe_next;
            fe_reg   <= fe_next;
            pe_reg   <= pe_next;
            oe_reg   <= oe_next;
            tend_reg <= tend_next;
            // Busy bits are registered and trail the engine by one cycle
            tbsy_reg <= tx_busy && !soft_rst;
            rbsy_reg <= rx_busy && !soft_rst;
            rx_count_reg <= rx_count_next;
            if (rx_pop)
                rx_buf_reg[0] <= rx_buf_reg[1];
            if (rx_push)
                rx_buf_reg[rx_slot[0]] <= rx_byte;
            irq_reg <= |pending;
        end
    end

    assign s_axi_awready   = awready_reg;
    assign s_axi_wready    = wready_reg;
    assign s_axi_bvalid    = bvalid_reg;
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_arready   = arready_reg;
    assign s_axi_rvalid    = rvalid_reg;
    assign s_axi_rdata     = rdata_reg;
    assign s_axi_rresp     = rresp_reg;
    assign tx_byte         = txd_reg;
    assign tx_buffer_empty = tbe_reg;
    assign clock_select    = clk_sel_reg;
    assign line_mode       = mode_reg;
    assign baud_divider    = baud_reg;
    assign port_enable     = ctl_reg[CTL_ENABLE_BIT];
    assign irq             = irq_reg;
endmodule

// ==== verif/uart_flag_properties.sv ====
`timescale 1ns/100ps
module uart_flag_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        tx_taken,
    input wire logic        tx_buffer_empty,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    tbe_reset_a: assert property ($rose(aresetn) |-> tx_buffer_empty)
        else $error("tx empty flag low after reset");
    tbe_set_a: assert property (tx_taken |=> tx_buffer_empty)
        else $error("tx empty flag not set by take");
    // The flag falls at the same edge that raises the write answer
    tbe_clear_a: assert property ($fell(tx_buffer_empty) |->
        s_axi_bvalid) else $error("tx empty fell without write");
    irq_quiet_a: assert property ($rose(aresetn) |-> !irq)
        else $error("irq high after reset");
    read_answer_a: assert property (s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer late or upper bits set");
    // Bound is loose on purpose: aw and w may be taken apart
    write_answer_a: assert property (s_axi_awready |-> ##[1:8] s_axi_bvalid)
        else $error("write answer missing");
endmodule
bind uart_status_flag_logic uart_flag_properties props (.*);

// ==== verif/uart_far_model.sv ====
`timescale 1ns/100ps
// Stands in for the serial engine: delivers received bytes and strobes transmit take and end
module uart_far_model (
    input wire logic  aclk,
    output logic       tx_taken,
    output logic       tx_end,
    output logic       tx_busy,
    output logic       rx_valid,
    output logic [7:0] rx_byte,
    output logic       rx_framing_err,
    output logic       rx_parity_err,
    output logic       rx_busy
);
    initial begin
        {tx_taken, tx_end, tx_busy, rx_valid, rx_busy} = 5'h00;
        {rx_byte, rx_framing_err, rx_parity_err} = 10'h000;
    end
    // Data lines flip after the strobe so stale bytes never look valid
    task automatic recv(input logic [7:0] b, input logic fe, pe);
        @(posedge aclk);
        rx_busy <= 1'b1;
        repeat (4) @(posedge aclk);
        {rx_valid, rx_byte, rx_framing_err, rx_parity_err} <=
            {1'b1, b, fe, pe};
        @(posedge aclk);
        {rx_valid, rx_byte, rx_framing_err, rx_parity_err} <=
            {1'b0, ~b, !fe, !pe};
        rx_busy <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic take();
        @(posedge aclk);
        tx_busy <= 1'b1;
        repeat (4) @(posedge aclk);
        {tx_taken, tx_end} <= 2'b11;
        @(posedge aclk);
        {tx_taken, tx_end, tx_busy} <= 3'b000;
        @(posedge aclk);
    endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import uart_flag_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        tx_taken, tx_end, tx_busy, rx_valid, rx_framing_err;
    logic        rx_parity_err, rx_busy, tx_buffer_empty, port_enable, irq;
    logic [7:0]  rx_byte, tx_byte;
    logic [15:0] clock_select, line_mode, baud_divider;
    int          mismatches, compares, cyc;
    logic [29:0] it [5] = '{IDX_CLOCK_SELECT, IDX_LINE_MODE, IDX_BAUD_DIVIDER,
                            IDX_PORT_CONTROL, IDX_IRQ_ENABLES};
    logic [15:0] mt [5] = '{MASK_CLOCK_SELECT, MASK_LINE_MODE,
                            MASK_BAUD_DIVIDER, MASK_PORT_CONTROL,
                            MASK_IRQ_ENABLES};
    uart_status_flag_logic dut (.*);
    uart_far_model far (.*);
    ////////////////////////////////////////////////////////////
    task automatic ck(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [29:0] i, input logic [15:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        forever begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        ck({14'h0000, s_axi_bresp}, {14'h0000, er});
    endtask
    task automatic rd(input logic [29:0] i, input logic [15:0] ed,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        forever begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        ck(s_axi_rdata[15:0], ed);
        ck({14'h0000, s_axi_rresp}, {14'h0000, er});
    endtask
    task test_done;
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // A hang in a handshake loop ends here instead of running forever
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done;
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0f;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_STATUS, 16'h0001, RESP_OKAY);
        for (int k = 0; k < 5; k++) begin
            rd(it[k], RST_CONFIG, RESP_OKAY);
            wr(it[k], 16'hffff, RESP_OKAY);
            rd(it[k], mt[k], RESP_OKAY);
        end
        repeat (3) @(posedge aclk);
        ck({14'h0000, port_enable, irq}, 16'h0003);
        ck(clock_select, MASK_CLOCK_SELECT);
        ck(line_mode, MASK_LINE_MODE);
        ck(baud_divider, MASK_BAUD_DIVIDER);
        for (int k = 0; k < 5; k++) wr(it[k], 16'h0000, RESP_OKAY);
        wr(30'h00005201, 16'hffff, RESP_SLVERR);
        rd(30'h00005201, 16'h0000, RESP_SLVERR);
        wr(IDX_TRANSMIT, 16'h005a, RESP_OKAY);
        ck({7'h00, tx_buffer_empty, tx_byte}, 16'h005a);
        wr(IDX_STATUS, 16'hffff, RESP_OKAY);
        rd(IDX_STATUS, 16'h0000, RESP_OKAY);
        far.take();
        rd(IDX_STATUS, 16'h0041, RESP_OKAY);
        wr(IDX_STATUS, 16'h0000, RESP_OKAY);
        rd(IDX_STATUS, 16'h0041, RESP_OKAY);
        wr(IDX_STATUS, 16'h0040, RESP_OKAY);
        rd(IDX_STATUS, 16'h0001, RESP_OKAY);
        far.recv(8'h11, 1'b1, 1'b0);
        rd(IDX_STATUS, 16'h0023, RESP_OKAY);
        wr(IDX_STATUS, 16'hffff, RESP_OKAY);
        rd(IDX_STATUS, 16'h0003, RESP_OKAY);
        far.recv(8'h22, 1'b0, 1'b1);
        rd(IDX_STATUS, 16'h0017, RESP_OKAY);
        rd(IDX_RECEIVE, 16'h0011, RESP_OKAY);
        rd(IDX_STATUS, 16'h0003, RESP_OKAY);
        far.recv(8'h33, 1'b0, 1'b0);
        far.recv(8'h44, 1'b0, 1'b0);
        rd(IDX_STATUS, 16'h000f, RESP_OKAY);
        rd(IDX_RECEIVE, 16'h0022, RESP_OKAY);
        rd(IDX_RECEIVE, 16'h0033, RESP_OKAY);
        rd(IDX_STATUS, 16'h0009, RESP_OKAY);
        wr(IDX_STATUS, 16'h0008, RESP_OKAY);
        rd(IDX_STATUS, 16'h0001, RESP_OKAY);
        wr(IDX_IRQ_ENABLES, 16'h0040, RESP_OKAY);
        repeat (3) @(posedge aclk);
        ck({15'h0000, irq}, 16'h0000);
        far.take();
        repeat (3) @(posedge aclk);
        ck({15'h0000, irq}, 16'h0001);
        // Upper lane only: neither the clear nor the transmit load applies
        s_axi_wstrb <= 4'h2;
        wr(IDX_STATUS, 16'h0040, RESP_OKAY);
        wr(IDX_TRANSMIT, 16'h00a5, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        repeat (3) @(posedge aclk);
        ck({15'h0000, irq}, 16'h0001);
        ck({7'h00, tx_buffer_empty, tx_byte}, 16'h015a);
        wr(IDX_STATUS, 16'h0040, RESP_OKAY);
        repeat (3) @(posedge aclk);
        ck({15'h0000, irq}, 16'h0000);
        test_done;
    end
endmodule
